/* primary_cache_status_control.sv */
// Status and control register of the primary cache with error capture and cache gating.
`timescale 1ns/100ps
`include "cache_status_regs.svh"

// Behaviour
// - First-fault flag sets on machine-check error; reset or write-one clears it.
// - While first-fault set, error type and error address stay frozen.
// - First-fault set stops cache use; contents and enable bit are kept.
// - Nested-fault flag sets on machine-check error while first-fault already set.
// - Nested fault keeps first error's type and address unchanged.
// - Nested fault disables cache, keeps enable bit; reset or write-one clears.
// - Interrupt flag sets on error reported as soft-error interrupt.
// - Interrupt error captures type only when neither interrupt nor first-fault set.
// - Interrupt flag disables cache, keeps enable bit; reset or write-one clears.
// - Hit latch holds tag comparator on every data read, write, invalidate.
// - Refresh enable gates refresh, counter increment and refresh timer; reset clears.
// - Writing one to invalidate-all flushes valid bits; bit self-clears, reads zero.
// - Cache enabled caches both streams, reports parity errors, never caches I/O.
// - Cache disabled makes every reference a miss unless hit override is set; reset clears enable.
// - Hit override reports hit for memory references, writes still go out.
// - Hit override suppresses data-stream tag and data parity reports.
// - Hit override leaves local bus parity and bus error reports alone.
// - Bits 31 to 13 read zero and ignore writes.
module primary_cache_status_control
    import cache_status_pkg::*;
(
    input  wire logic  clk,               // CPU clock, 20 MHz.
    input  wire logic  rst_n,             // Asynchronous reset, active low.
    input  wire logic  proc_reg_write,    // Internal register write strobe.
    input  wire logic  proc_reg_read,     // Internal register read strobe.
    input  wire logic [7:0] reg_num,      // Internal register number.
    input  wire word_t wr_data,           // Write data.
    output word_t      rd_data,           // Read data, registered.
    input  wire logic  err_valid,         // Error detected this cycle.
    input  wire report_kind_t err_kind,   // How the error is reported.
    input  wire err_type_t err_type,      // Error type bits for this error.
    input  wire word_t err_addr,          // Physical address of the error.
    input  wire logic  err_is_tag_par,    // Error is a tag parity error.
    input  wire logic  err_is_data_par,   // Error is a cache data parity error.
    input  wire logic  ref_valid,         // Reference cycle this cycle.
    input  wire logic  ref_dstream,       // Reference is data stream.
    input  wire logic  ref_io,            // Reference is to I/O space.
    input  wire logic  tag_match,         // Tag comparator output.
    input  wire logic  refresh_tick,      // Refresh timer would count this cycle.
    output logic       cache_hit,         // Reference reported as hit.
    output logic       cache_active,      // Cache usable for lookups.
    output logic       parity_report_en,  // Cache parity errors may be reported.
    output logic       flush_pulse,       // Clear every valid bit, one cycle.
    output logic       refresh_step,      // Refresh and counter advance pulse.
    output logic       refresh_run,       // Refresh timer allowed to run.
    output word_t      error_address_latch // Captured error address.
);

    logic      first_fault_flag;
    logic      nested_fault_flag;
    logic      intr_flag;
    logic      hit_latch_reg;
    logic      refresh_en_reg;
    logic      cache_enable;
    logic      hit_override_reg;
    logic      inval_all_reg;
    err_type_t err_type_reg;
    logic      sel_write;
    logic      mcheck_evt;
    logic      intr_evt;
    logic      clr_first;
    logic      clr_nested;
    logic      clr_intr;
    logic      err_suppressed;
    logic      err_kept;
    logic      cache_blocked;
    word_t     status_word;

    assign sel_write = proc_reg_write && (reg_num == `CSC_REG_NUM);
    assign clr_first  = sel_write && wr_data[`CSC_FIRST_FAULT_BIT];
    assign clr_nested = sel_write && wr_data[`CSC_NESTED_FAULT_BIT];
    assign clr_intr   = sel_write && wr_data[`CSC_INTR_FLAG_BIT];

    // Under hit override, cache parity errors on data-stream references are not reported.
    assign err_suppressed = hit_override_reg && ref_dstream && (err_is_tag_par || err_is_data_par);
    assign err_kept   = err_valid && !err_suppressed;
    assign mcheck_evt = err_kept && (err_kind == REPORT_MCHECK);
    assign intr_evt   = err_kept && (err_kind == REPORT_INTR);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_fault_flag <= 1'b0;
        end else if (mcheck_evt && !first_fault_flag) begin
            first_fault_flag <= 1'b1;
        end else if (clr_first) begin
            first_fault_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nested_fault_flag <= 1'b0;
        end else if (mcheck_evt && first_fault_flag) begin
            nested_fault_flag <= 1'b1;
        end else if (clr_nested) begin
            nested_fault_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intr_flag <= 1'b0;
        end else if (intr_evt) begin
            intr_flag <= 1'b1;
        end else if (clr_intr) begin
            intr_flag <= 1'b0;
        end
    end

    // Error type follows the first unlocked error; a machine check may override an interrupt capture.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_type_reg <= `CSC_ERR_TYPE_RESET;
        end else if (mcheck_evt && !first_fault_flag) begin
            err_type_reg <= err_type;
        end else if (intr_evt && !intr_flag && !first_fault_flag) begin
            err_type_reg <= err_type;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            error_address_latch <= `ERR_ADDR_RESET;
        end else if (mcheck_evt && !first_fault_flag) begin
            error_address_latch <= err_addr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_latch_reg <= 1'b0;
        end else if (ref_valid && ref_dstream) begin
            hit_latch_reg <= tag_match;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_en_reg   <= 1'b0;
            cache_enable     <= 1'b0;
            hit_override_reg <= 1'b0;
        end else if (sel_write) begin
            refresh_en_reg   <= wr_data[`CSC_REFRESH_EN_BIT];
            cache_enable     <= wr_data[`CSC_CACHE_EN_BIT];
            hit_override_reg <= wr_data[`CSC_HIT_OVERRIDE_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inval_all_reg <= 1'b0;
        end else begin
            inval_all_reg <= sel_write && wr_data[`CSC_INVAL_ALL_BIT];
        end
    end

    // Any error flag blocks lookups while the enable bit keeps its value.
    assign cache_blocked = first_fault_flag || nested_fault_flag || intr_flag;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_hit        <= 1'b0;
            cache_active     <= 1'b0;
            parity_report_en <= 1'b0;
            flush_pulse      <= 1'b0;
            refresh_step     <= 1'b0;
            refresh_run      <= 1'b0;
        end else begin
            cache_active     <= cache_enable && !cache_blocked;
            parity_report_en <= cache_enable && !cache_blocked;
            if (!ref_valid || ref_io) begin
                cache_hit <= 1'b0;
            end else if (hit_override_reg) begin
                cache_hit <= 1'b1;
            end else begin
                cache_hit <= cache_enable && !cache_blocked && tag_match;
            end
            flush_pulse      <= sel_write && wr_data[`CSC_INVAL_ALL_BIT];
            refresh_step     <= refresh_en_reg && refresh_tick;
            refresh_run      <= refresh_en_reg;
        end
    end

    always_comb begin
        status_word = `CSC_RESET_VALUE;
        status_word[`CSC_ERR_TYPE_HI:`CSC_ERR_TYPE_LO] = err_type_reg;
        status_word[`CSC_FIRST_FAULT_BIT]  = first_fault_flag;
        status_word[`CSC_NESTED_FAULT_BIT] = nested_fault_flag;
        status_word[`CSC_INTR_FLAG_BIT]    = intr_flag;
        status_word[`CSC_HIT_LATCH_BIT]    = hit_latch_reg;
        status_word[`CSC_REFRESH_EN_BIT]   = refresh_en_reg;
        status_word[`CSC_INVAL_ALL_BIT]    = 1'b0;
        status_word[`CSC_CACHE_EN_BIT]     = cache_enable;
        status_word[`CSC_HIT_OVERRIDE_BIT] = hit_override_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `CSC_RESET_VALUE;
        end else if (proc_reg_read && (reg_num == `CSC_REG_NUM)) begin
            rd_data <= status_word;
        end else begin
            rd_data <= `CSC_RESET_VALUE;
        end
    end

    first_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        mcheck_evt |=> first_fault_flag)
        else $error("First-fault flag not set after machine check.");

    addr_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        first_fault_flag |=> $stable(error_address_latch))
        else $error("Error address changed while first fault held.");

    blocked_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cache_blocked && !hit_override_reg) ##1 cache_blocked |-> !cache_active)
        else $error("Cache active while an error flag is set.");

    nested_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mcheck_evt && first_fault_flag) |=> nested_fault_flag && $stable(err_type_reg))
        else $error("Nested fault not recorded or type overwritten.");

    intr_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (intr_flag && !mcheck_evt) |=> $stable(err_type_reg))
        else $error("Error type changed while interrupt flag held.");

    enable_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
        (err_valid && !sel_write) |=> $stable(cache_enable))
        else $error("Cache enable changed by an error.");

    flush_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_write && wr_data[`CSC_INVAL_ALL_BIT]) |=> flush_pulse ##1 !inval_all_reg || flush_pulse)
        else $error("Invalidate-all did not pulse.");

    override_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ref_valid && !ref_io && hit_override_reg) |=> cache_hit)
        else $error("Hit override did not force a hit.");

    disabled_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ref_valid && !cache_enable && !hit_override_reg) |=> !cache_hit)
        else $error("Hit reported with cache disabled.");

    refresh_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !refresh_en_reg |=> !refresh_step)
        else $error("Refresh stepped while disabled.");

    high_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_data[31:13] == 19'h0_0000)
        else $error("Reserved status bits read nonzero.");

    first_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clr_first && !mcheck_evt) |=> !first_fault_flag)
        else $error("First-fault flag not cleared by a write of one.");

    mcheck_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mcheck_evt && !first_fault_flag) |=> (error_address_latch == $past(err_addr)) && (err_type_reg == $past(err_type)))
        else $error("First machine check not captured.");

    first_type_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        first_fault_flag |=> $stable(err_type_reg))
        else $error("Error type changed while first fault held.");

    nested_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mcheck_evt && first_fault_flag) |=> $stable(error_address_latch))
        else $error("Nested fault overwrote the error address.");

    nested_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clr_nested && !(mcheck_evt && first_fault_flag)) |=> !nested_fault_flag)
        else $error("Nested-fault flag not cleared by a write of one.");

    intr_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        intr_evt |=> intr_flag)
        else $error("Interrupt flag not set after interrupt error.");

    type_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        (intr_evt && !intr_flag && !first_fault_flag) |=> (err_type_reg == $past(err_type)))
        else $error("Interrupt error type not captured.");

    intr_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clr_intr && !intr_evt) |=> !intr_flag)
        else $error("Interrupt flag not cleared by a write of one.");

    hit_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ref_valid && ref_dstream) |=> (hit_latch_reg == $past(tag_match)))
        else $error("Hit latch did not follow the tag comparator.");

    hit_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(ref_valid && ref_dstream) |=> $stable(hit_latch_reg))
        else $error("Hit latch changed without a data reference.");

    refresh_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (refresh_en_reg && refresh_tick) |=> refresh_step)
        else $error("Refresh did not step while enabled.");

    refresh_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        refresh_en_reg |=> refresh_run)
        else $error("Refresh timer stopped while enabled.");

    flush_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flush_pulse && !sel_write) |=> !flush_pulse)
        else $error("Invalidate-all pulse lasted more than one cycle.");

    io_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ref_valid && ref_io) |=> !cache_hit)
        else $error("I/O reference reported as a hit.");

    enabled_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ref_valid && !ref_io && cache_enable && !cache_blocked && !hit_override_reg) |=> (cache_hit == $past(tag_match)))
        else $error("Enabled cache hit differs from the tag comparator.");

    blocked_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ref_valid && cache_blocked && !hit_override_reg) |=> !cache_hit)
        else $error("Hit reported while an error flag is set.");

    active_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cache_enable |=> !cache_active && !parity_report_en)
        else $error("Cache active with the enable bit clear.");

    suppress_a: assert property (@(posedge clk) disable iff (!rst_n)
        (err_valid && err_suppressed && !sel_write) |=> $stable({first_fault_flag, nested_fault_flag, intr_flag}))
        else $error("Suppressed parity error changed an error flag.");

    bus_err_intr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (err_valid && (err_kind == REPORT_INTR) && !err_is_tag_par && !err_is_data_par) |=> intr_flag)
        else $error("Non-parity interrupt error not reported.");

    bus_err_mc_a: assert property (@(posedge clk) disable iff (!rst_n)
        (err_valid && (err_kind == REPORT_MCHECK) && !err_is_tag_par && !err_is_data_par && !sel_write) |=> first_fault_flag)
        else $error("Non-parity machine check not reported.");

    read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        (proc_reg_read && (reg_num == `CSC_REG_NUM)) |=> (rd_data == $past(status_word)))
        else $error("Read data differs from the status word.");

    ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_write && !err_valid && !ref_valid) |=> $stable(err_type_reg) && $stable(hit_latch_reg))
        else $error("Write changed a read-only status field.");

    first_w0_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_write && !wr_data[`CSC_FIRST_FAULT_BIT] && first_fault_flag) |=> first_fault_flag)
        else $error("Writing zero cleared the first-fault flag.");

    intr_w0_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_write && !wr_data[`CSC_INTR_FLAG_BIT] && intr_flag) |=> intr_flag)
        else $error("Writing zero cleared the interrupt flag.");

endmodule // primary_cache_status_control

/* cache_status_regs.svh */
// Register offsets, field positions and reset values of the cache status and control register.
`ifndef CACHE_STATUS_REGS_SVH
`define CACHE_STATUS_REGS_SVH

`define CSC_REG_NUM          8'h7F
`define CSC_RESET_VALUE      32'h0000_0000
`define CSC_ERR_TYPE_HI      12
`define CSC_ERR_TYPE_LO      8
`define CSC_FIRST_FAULT_BIT  7
`define CSC_NESTED_FAULT_BIT 6
`define CSC_INTR_FLAG_BIT    5
`define CSC_HIT_LATCH_BIT    4
`define CSC_REFRESH_EN_BIT   3
`define CSC_INVAL_ALL_BIT    2
`define CSC_CACHE_EN_BIT     1
`define CSC_HIT_OVERRIDE_BIT 0
`define CSC_ERR_TYPE_RESET   5'h00
`define ERR_ADDR_RESET       32'h0000_0000

`endif

/* cache_status_pkg.sv */
// Types shared by the cache status and control logic.
package cache_status_pkg;

    typedef logic [4:0]  err_type_t;
    typedef logic [31:0] word_t;

    // How a detected error is reported to the core.
    typedef enum logic [1:0] {
        REPORT_NONE   = 2'b00,
        REPORT_INTR   = 2'b01,
        REPORT_MCHECK = 2'b11
    } report_kind_t;

endpackage

/* cpu_core_model.sv */
// Core-side model that issues internal register writes and reads.
`timescale 1ns/100ps
module cpu_core_model
    import cache_status_pkg::*;
(
    input  wire logic  clk,            // CPU clock.
    output logic       proc_reg_write, // Write strobe.
    output logic       proc_reg_read,  // Read strobe.
    output logic [7:0] reg_num,        // Register number.
    output word_t      wr_data,        // Write data.
    input  wire word_t rd_data         // Read data.
);
    initial begin
        proc_reg_write = 1'b0;
        proc_reg_read  = 1'b0;
        reg_num        = 8'h00;
        wr_data        = 32'h0000_0000;
    end

    // Released lines take the inverse so that stale values are never mistaken for live ones.
    task automatic reg_write(input word_t d);
        @(posedge clk);
        proc_reg_write <= 1'b1;
        reg_num        <= 8'h7F;
        wr_data        <= d;
        @(posedge clk);
        proc_reg_write <= 1'b0;
        reg_num        <= ~reg_num;
        wr_data        <= ~d;
        #1;
    endtask

    task automatic reg_read(output word_t d);
        @(posedge clk);
        proc_reg_read <= 1'b1;
        reg_num       <= 8'h7F;
        @(posedge clk);
        proc_reg_read <= 1'b0;
        reg_num       <= ~reg_num;
        #1;
        d = rd_data;
    endtask
endmodule // cpu_core_model

/* primary_cache_status_control_tb.sv */
// Self-checking testbench of the cache status and control register.
`timescale 1ns/100ps
module primary_cache_status_control_tb
    import cache_status_pkg::*;
;
    logic clk, rst_n, wr, rd, err_valid, ref_valid, ref_dstream, ref_io, tag_match, tick, tpar, dpar;
    logic hit, active, par_en, flush, step, run;
    logic [7:0] reg_num;
    word_t wr_data, rd_data, eaddr, r, eal;
    report_kind_t err_kind;
    err_type_t err_type;
    int miscompares = 0;
    int n_checks = 0;

    cpu_core_model u_cpu_core_model (.clk(clk), .proc_reg_write(wr), .proc_reg_read(rd),
        .reg_num(reg_num), .wr_data(wr_data), .rd_data(rd_data));
    primary_cache_status_control u_primary_cache_status_control (.clk(clk), .rst_n(rst_n),
        .proc_reg_write(wr), .proc_reg_read(rd), .reg_num(reg_num), .wr_data(wr_data),
        .rd_data(rd_data), .err_valid(err_valid), .err_kind(err_kind), .err_type(err_type),
        .err_addr(eaddr), .err_is_tag_par(tpar), .err_is_data_par(dpar), .ref_valid(ref_valid),
        .ref_dstream(ref_dstream), .ref_io(ref_io), .tag_match(tag_match), .refresh_tick(tick),
        .cache_hit(hit), .cache_active(active), .parity_report_en(par_en), .flush_pulse(flush),
        .refresh_step(step), .refresh_run(run), .error_address_latch(eal));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rd_chk(input word_t exp);
        word_t v;
        u_cpu_core_model.reg_read(v);
        check(v, exp);
    endtask

    task automatic err(input report_kind_t k, input err_type_t t, input word_t a);
        @(posedge clk);
        err_valid <= 1'b1;
        err_kind  <= k;
        err_type  <= t;
        eaddr     <= a;
        @(posedge clk);
        err_valid <= 1'b0;
        err_kind  <= REPORT_NONE;
        eaddr     <= ~a;
        #1;
    endtask

    task automatic ref_cyc(input logic io, input logic tm, input logic exp);
        @(posedge clk);
        ref_valid   <= 1'b1;
        ref_dstream <= 1'b1;
        ref_io      <= io;
        tag_match   <= tm;
        @(posedge clk);
        ref_valid   <= 1'b0;
        tag_match   <= ~tm;
        #1;
        check(hit, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #200_000;
        miscompares++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        {err_valid, ref_valid, ref_dstream, ref_io, tag_match, tick, tpar, dpar} = '0;
        err_kind = REPORT_NONE;
        err_type = 5'h00;
        eaddr    = 32'h0000_0000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(32'h0000_0000);
        u_cpu_core_model.reg_write(32'hFFFF_FFFF);
        check(flush, 1'b1);
        @(posedge clk);
        #1;
        check(flush, 1'b0);
        check({active, par_en, run}, 3'b111);
        rd_chk(32'h0000_000B);
        ref_cyc(1'b0, 1'b0, 1'b1);
        ref_cyc(1'b1, 1'b0, 1'b0);
        u_cpu_core_model.reg_write(32'h0000_000A);
        ref_cyc(1'b0, 1'b1, 1'b1);
        rd_chk(32'h0000_001A);
        ref_cyc(1'b0, 1'b0, 1'b0);
        rd_chk(32'h0000_000A);
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        #1;
        check(step, 1'b1);
        u_cpu_core_model.reg_write(32'h0000_0002);
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        #1;
        check({step, run}, 2'b00);
        err(REPORT_INTR, 5'h15, 32'h0000_0000);
        rd_chk(32'h0000_1522);
        check(active, 1'b0);
        err(REPORT_INTR, 5'h0A, 32'h0000_0000);
        u_cpu_core_model.reg_write(32'h0000_0002);
        rd_chk(32'h0000_1522);
        err(REPORT_MCHECK, 5'h03, 32'h0000_1234);
        rd_chk(32'h0000_03A2);
        check(eal, 32'h0000_1234);
        err(REPORT_MCHECK, 5'h1F, 32'h5555_AAA0);
        rd_chk(32'h0000_03E2);
        check(eal, 32'h0000_1234);
        ref_cyc(1'b0, 1'b1, 1'b0);
        u_cpu_core_model.reg_write(32'h0000_00E2);
        u_cpu_core_model.reg_read(r);
        check(r, 32'h0000_0312);
        check(active, 1'b1);
        u_cpu_core_model.reg_write(32'h0000_0003);
        @(posedge clk);
        tpar <= 1'b1;
        err(REPORT_MCHECK, 5'h11, 32'h0000_0040);
        @(posedge clk);
        {tpar, dpar} <= 2'b01;
        err(REPORT_INTR, 5'h12, 32'h0000_0040);
        @(posedge clk);
        dpar <= 1'b0;
        rd_chk(32'h0000_0313);
        check(eal, 32'h0000_1234);
        err(REPORT_INTR, 5'h08, 32'h0000_0000);
        rd_chk(32'h0000_0833);
        @(posedge clk);
        {ref_dstream, tpar} <= 2'b01;
        err(REPORT_MCHECK, 5'h09, 32'h0000_0080);
        rd_chk(32'h0000_09B3);
        check(eal, 32'h0000_0080);
        results();
    end
endmodule // primary_cache_status_control_tb
